// ### hdl/dmal_pkg.sv
// Purpose: Shared constants for the math datapath of the audio DSP core.
// Assumes: 32-bit instruction words and one core clock.
// Notes:   Opcodes are the seven-bit operation field, bits 31:25.
package dmal_pkg;

    // ==================================================================
    // Instruction field positions.
    localparam int OP_MSB    = 31;  // Top of the operation field.
    localparam int OP_LSB    = 25;  // Bottom of the operation field.
    localparam int RFLD_MSB  = 23;  // Top of the register field.
    localparam int RFLD_LSB  = 16;  // Bottom of the register field.
    localparam int SRC1_MSB  = 20;  // Top of the first register number.
    localparam int MFLD_MSB  = 15;  // Top of the immediate/second field.
    localparam int SRC2_MSB  = 4;   // Top of the second register number.
    localparam int SHAMT_MSB = 4;   // Top of a shift amount.

    // ==================================================================
    // Operation codes.
    localparam logic [6:0] MAGNITUDE_OP          = 7'h00;
    localparam logic [6:0] WIDE_ACC_CLEAR_OP     = 7'h01;
    localparam logic [6:0] INT_IMM_ADD_OP        = 7'h02;
    localparam logic [6:0] WRAP_REG_ADD_OP       = 7'h03;
    localparam logic [6:0] SAT_REG_ADD_OP        = 7'h04;
    localparam logic [6:0] FRAC_IMM_SAT_ADD_OP   = 7'h05;
    localparam logic [6:0] WRAP_REG_SUBTRACT_OP  = 7'h06;
    localparam logic [6:0] SAT_REG_SUBTRACT_OP   = 7'h07;
    localparam logic [6:0] LOGIC_LEFT_IMM_OP     = 7'h08;
    localparam logic [6:0] LOGIC_LEFT_REG_OP     = 7'h09;
    localparam logic [6:0] SAT_LEFT_IMM_OP       = 7'h0A;
    localparam logic [6:0] SAT_LEFT_REG_OP       = 7'h0B;
    localparam logic [6:0] LOGIC_RIGHT_IMM_OP    = 7'h0C;
    localparam logic [6:0] LOGIC_RIGHT_REG_OP    = 7'h0D;
    localparam logic [6:0] ARITH_RIGHT_IMM_OP    = 7'h0E;
    localparam logic [6:0] ARITH_RIGHT_REG_OP    = 7'h0F;
    localparam logic [6:0] REG_MUL_ACCUMULATE_OP = 7'h10;

    // ==================================================================
    // Operand select codes beyond the sixteen general registers.
    localparam logic [4:0] SEL_NARROW_ACC = 5'h10; // 32-bit accumulator.
    localparam logic [4:0] SEL_FLAGS      = 5'h11; // Flags register.

    // ==================================================================
    // Saturation limits and reset values.
    localparam logic [31:0] MAX_POS_32   = 32'h7FFFFFFF;
    localparam logic [31:0] MAX_NEG_32   = 32'h80000000;
    localparam logic [63:0] MAX_POS_64   = 64'h7FFFFFFFFFFFFFFF;
    localparam logic [63:0] MAX_NEG_64   = 64'h8000000000000000;
    localparam logic [31:0] NARROW_RESET = 32'h00000000;
    localparam logic [63:0] WIDE_RESET   = 64'h0000000000000000;

endpackage : dmal_pkg

// ### hdl/dmal_operand_mux.sv
// Purpose: Picks one 32-bit source operand by its five-bit select code.
// Assumes: General registers arrive flattened, register 0 in low bits.
// Notes:   Unused codes read as zero so a bad field cannot leak state.
`timescale 1ns/1ps
module dmal_operand_mux
    import dmal_pkg::*;
#(
    parameter int NUM_GPR = 16
) (
    input  wire logic [NUM_GPR*32-1:0] gpr_flat_i,
    input  wire logic [31:0]           narrow_acc_i,
    input  wire logic [31:0]           flags_i,
    input  wire logic [4:0]            sel_i,
    output logic      [31:0]           operand_o
);

    // ==================================================================
    // Selection.
    // Handshake-free combinational path; the consumer registers it.
    always_comb begin
        operand_o = 32'h00000000;
        if (sel_i < 5'(NUM_GPR)) begin
            operand_o = gpr_flat_i[32*sel_i +: 32];
        end else if (sel_i == SEL_NARROW_ACC) begin
            operand_o = narrow_acc_i;
        end else if (sel_i == SEL_FLAGS) begin
            operand_o = flags_i;
        end
    end

endmodule : dmal_operand_mux

// ### hdl/dmal_datapath.sv
// Purpose: Math and shift execution unit writing the two accumulators.
// Assumes: Instruction and register values come from same-clock logic.
// Notes:   Every accepted operation completes on the next clock edge.
`timescale 1ns/1ps

// Notes on behaviour
// - Magnitude of source into narrow accumulator.
// - Clear opcode zeroes the wide accumulator.
// - Sign-extended immediate added with wraparound.
// - Unsigned register add wraps, carry dropped.
// - Signed register add clamps at limits.
// - Fractional immediate in upper half, saturating add.
// - Unsigned subtract first minus second, wrapping.
// - Signed subtract clamps at both limits.
// - Logical left shift, zero fill.
// - Saturating left shift clamps on lost bits.
// - Logical right shift, zero fill at top.
// - Arithmetic right shift replicates sign bit.
// - Fractional multiply-accumulate into wide, saturating.
// - Register numbers from bits 20:16, 4:0.
// - Operation, register, immediate field positions.
// - Operands select general, accumulator, or flags.
module dmal_datapath
    import dmal_pkg::*;
#(
    parameter int NUM_GPR = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  instr_valid_i,
    input  wire logic [31:0]           instr_i,
    input  wire logic [NUM_GPR*32-1:0] gpr_flat_i,
    input  wire logic [31:0]           flags_i,
    output logic      [31:0]           narrow_acc_o,
    output logic      [63:0]           wide_acc_o,
    output logic                       narrow_wr_o,
    output logic                       wide_wr_o,
    output logic                       unknown_op_o
);

    // ==================================================================
    // Elaboration checks.
    // ==================================================================
    // Select codes 16 and 17 are the accumulator and flags registers.
    if (NUM_GPR < 1 || NUM_GPR > 16) begin : g_bad_gpr
        $error("NUM_GPR must lie between 1 and 16.");
    end

    // ==================================================================
    // State.
    // ==================================================================
    logic [31:0] narrow_reg;     // Narrow accumulator.
    logic [63:0] wide_reg;       // Wide accumulator.
    logic        narrow_wr_reg;  // Narrow accumulator written last edge.
    logic        wide_wr_reg;    // Wide accumulator written last edge.
    logic        unknown_reg;    // Unsupported opcode seen last edge.

    // ==================================================================
    // Instruction decode.
    // ==================================================================
    logic [6:0]  op;            // Operation field.
    logic [4:0]  src1_sel;      // First register number.
    logic [4:0]  src2_sel;      // Second register number.
    logic [15:0] imm16;         // Immediate field.
    logic [4:0]  imm_shamt;     // Immediate shift amount.
    logic [31:0] src1;          // First operand value.
    logic [31:0] src2;          // Second operand value.

    assign op        = instr_i[OP_MSB:OP_LSB];
    assign src1_sel  = instr_i[SRC1_MSB:RFLD_LSB];
    assign src2_sel  = instr_i[SRC2_MSB:0];
    assign imm16     = instr_i[MFLD_MSB:0];
    assign imm_shamt = instr_i[SHAMT_MSB:0];

    // Both operand ports reach registers, accumulator and flags alike.
    dmal_operand_mux #(
        .NUM_GPR      (NUM_GPR)
    ) u_src1_mux (
        .gpr_flat_i   (gpr_flat_i),
        .narrow_acc_i (narrow_reg),
        .flags_i      (flags_i),
        .sel_i        (src1_sel),
        .operand_o    (src1)
    );

    dmal_operand_mux #(
        .NUM_GPR      (NUM_GPR)
    ) u_src2_mux (
        .gpr_flat_i   (gpr_flat_i),
        .narrow_acc_i (narrow_reg),
        .flags_i      (flags_i),
        .sel_i        (src2_sel),
        .operand_o    (src2)
    );

    // ==================================================================
    // Helper functions.
    // ==================================================================
    // Clamps a 33-bit signed result into 32 bits.
    function automatic logic [31:0] sat33(input logic [32:0] v);
        if (v[32] != v[31]) begin
            sat33 = v[32] ? MAX_NEG_32 : MAX_POS_32;
        end else begin
            sat33 = v[31:0];
        end
    endfunction : sat33

    // Left shift that clamps by sign when significant bits fall off.
    function automatic logic [31:0] sat_shl(input logic [31:0] v,
                                            input logic [4:0]  n);
        logic [31:0] sh;
        logic [31:0] back;

        sh   = v << n;
        back = 32'($signed(sh) >>> n);
        if (back != v) begin
            sat_shl = v[31] ? MAX_NEG_32 : MAX_POS_32;
        end else begin
            sat_shl = sh;
        end
    endfunction : sat_shl

    // ==================================================================
    // Narrow result computation.
    // ==================================================================
    logic [31:0] narrow_next;   // Narrow accumulator candidate.
    logic        narrow_hit;    // Operation targets the narrow one.
    logic [31:0] imm_sext;      // Sign-extended integer immediate.
    logic [31:0] imm_frac;      // Immediate placed in the upper half.
    logic [4:0]  reg_shamt;     // Shift amount from the second register.

    assign imm_sext  = {{16{imm16[15]}}, imm16};
    assign imm_frac  = {imm16, 16'h0000};
    assign reg_shamt = src2[SHAMT_MSB:0];

    // Pure function of decode and operands; no state is touched here.
    always_comb begin
        narrow_next = narrow_reg;
        narrow_hit  = 1'b1;
        unique case (op)
            // Magnitude of the selected operand.
            MAGNITUDE_OP: begin
                // Negating the most negative value would wrap, so clamp.
                if (src1 == MAX_NEG_32) begin
                    narrow_next = MAX_POS_32;
                end else if (src1[31]) begin
                    narrow_next = 32'(-src1);
                end else begin
                    narrow_next = src1;
                end
            end

            // Integer immediate add wraps like the register add.
            INT_IMM_ADD_OP: begin
                narrow_next = 32'(src1 + imm_sext);
            end

            WRAP_REG_ADD_OP: begin
                narrow_next = 32'(src1 + src2);
            end

            // Saturating forms add one guard bit, then clamp.
            SAT_REG_ADD_OP: begin
                narrow_next = sat33(33'({src1[31], src1}
                              + {src2[31], src2}));
            end

            FRAC_IMM_SAT_ADD_OP: begin
                narrow_next = sat33(33'({src1[31], src1}
                              + {imm_frac[31], imm_frac}));
            end

            // Subtracts take the second operand from the first.
            WRAP_REG_SUBTRACT_OP: begin
                narrow_next = 32'(src1 - src2);
            end

            SAT_REG_SUBTRACT_OP: begin
                narrow_next = sat33(33'({src1[31], src1}
                              - {src2[31], src2}));
            end

            // Left shifts fill the low end with zeros.
            LOGIC_LEFT_IMM_OP: begin
                narrow_next = src1 << imm_shamt;
            end

            LOGIC_LEFT_REG_OP: begin
                narrow_next = src1 << reg_shamt;
            end

            // Saturating left shifts clamp by the source sign.
            SAT_LEFT_IMM_OP: begin
                narrow_next = sat_shl(src1, imm_shamt);
            end

            SAT_LEFT_REG_OP: begin
                narrow_next = sat_shl(src1, reg_shamt);
            end

            // Logical right shifts fill the top with zeros.
            LOGIC_RIGHT_IMM_OP: begin
                narrow_next = src1 >> imm_shamt;
            end

            LOGIC_RIGHT_REG_OP: begin
                narrow_next = src1 >> reg_shamt;
            end

            // Arithmetic right shifts copy bit 31 downwards.
            ARITH_RIGHT_IMM_OP: begin
                narrow_next = 32'($signed(src1) >>> imm_shamt);
            end

            ARITH_RIGHT_REG_OP: begin
                narrow_next = 32'($signed(src1) >>> reg_shamt);
            end

            default: begin
                // The wide-accumulator and unknown codes land here.
                narrow_hit = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // Wide result computation.
    // ==================================================================
    logic [63:0] product;       // Signed 32x32 integer product.
    logic [65:0] wide_sum;      // Accumulator plus fractional product.
    logic [63:0] wide_mac;      // Saturated accumulate result.

    // The fractional product is the integer product doubled; -1 times -1
    // lands one past the top, which the wide sum and clamp absorb.
    always_comb begin
        product  = 64'($signed(src1))
                 * 64'($signed(src2));

        wide_sum = 66'($signed({{2{wide_reg[63]}}, wide_reg})
                 + $signed({product[63], product, 1'b0}));
        if (wide_sum[65:63] != {3{wide_sum[63]}}) begin
            wide_mac = wide_sum[65] ? MAX_NEG_64 : MAX_POS_64;
        end else begin
            wide_mac = wide_sum[63:0];
        end
    end

    // ==================================================================
    // Narrow accumulator.
    // ==================================================================
    // Written only by narrow operations; sources are never written.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            narrow_reg <= NARROW_RESET;
        end else if (instr_valid_i && narrow_hit) begin
            narrow_reg <= narrow_next;
        end
    end

    // ==================================================================
    // Wide accumulator.
    // ==================================================================
    // Clear demands every other field zero; otherwise it is unknown.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wide_reg <= WIDE_RESET;
        end else if (instr_valid_i) begin
            if (op == WIDE_ACC_CLEAR_OP
                && instr_i[24:0] == 25'h0000000) begin
                wide_reg <= WIDE_RESET;
            end else if (op == REG_MUL_ACCUMULATE_OP) begin
                wide_reg <= wide_mac;
            end
        end
    end

    // ==================================================================
    // Status strobes.
    // ==================================================================
    // One-cycle pulses mark which accumulator the last edge updated.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            narrow_wr_reg <= 1'b0;
            wide_wr_reg   <= 1'b0;
            unknown_reg   <= 1'b0;
        end else begin
            narrow_wr_reg <= instr_valid_i && narrow_hit;
            wide_wr_reg   <= instr_valid_i
                          && ((op == WIDE_ACC_CLEAR_OP
                               && instr_i[24:0] == 25'h0000000)
                              || op == REG_MUL_ACCUMULATE_OP);
            unknown_reg   <= instr_valid_i && !narrow_hit
                          && !(op == WIDE_ACC_CLEAR_OP
                               && instr_i[24:0] == 25'h0000000)
                          && op != REG_MUL_ACCUMULATE_OP;
        end
    end

    assign narrow_acc_o = narrow_reg;
    assign wide_acc_o   = wide_reg;
    assign narrow_wr_o  = narrow_wr_reg;
    assign wide_wr_o    = wide_wr_reg;
    assign unknown_op_o = unknown_reg;

endmodule : dmal_datapath

// ### verif/dmal_props.sv
// Purpose: Port-level assertions for the math datapath.
// Assumes: Results land one clock after an accepted instruction.
// Notes:   Operands are rebuilt here from the register inputs.
`timescale 1ns/1ps
module dmal_props
    import dmal_pkg::*;
#(
    parameter int NUM_GPR = 16
) (
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  instr_valid_i,
    input wire logic [31:0]           instr_i,
    input wire logic [NUM_GPR*32-1:0] gpr_flat_i,
    input wire logic [31:0]           flags_i,
    input wire logic [31:0]           narrow_acc_o,
    input wire logic [63:0]           wide_acc_o,
    input wire logic                  narrow_wr_o,
    input wire logic                  wide_wr_o,
    input wire logic                  unknown_op_o
);
    // ==================================================================
    // Operand rebuild.
    logic [31:0] a_reg;  // First operand seen at the taking edge.
    logic [31:0] b_reg;  // Second operand seen at the taking edge.
    logic [15:0] m_reg;  // Immediate field seen at the taking edge.

    // Codes above 17 read as zero, so a stray field shows no state.
    function automatic logic [31:0] pick(input logic [4:0] c);
        if (c < 5'h10) return gpr_flat_i[32*c +: 32];
        if (c == SEL_NARROW_ACC) return narrow_acc_o;
        if (c == SEL_FLAGS) return flags_i;
        return 32'h00000000;
    endfunction : pick

    // Captured every edge, so no property needs a deep history.
    always_ff @(posedge clk_i) begin
        a_reg <= pick(instr_i[20:16]);
        b_reg <= pick(instr_i[4:0]);
        m_reg <= instr_i[15:0];
    end

    // ==================================================================
    // Properties.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // An instruction of the given operation is taken at this edge.
    sequence s_take(logic [6:0] op);
        instr_valid_i && instr_i[31:25] == op;
    endsequence
    // The narrow result was written and the operation was accepted.
    sequence s_narrow_done;
        narrow_wr_o && !unknown_op_o;
    endsequence

    mag_result_a: assert property (s_take(MAGNITUDE_OP) |=> s_narrow_done ##0
        narrow_acc_o == ((a_reg == MAX_NEG_32) ? MAX_POS_32 :
        (a_reg[31] ? 32'h00000000 - a_reg : a_reg)))
        else $error("magnitude result wrong");
    add_wrap_a: assert property (s_take(WRAP_REG_ADD_OP) |=> s_narrow_done
        ##0 narrow_acc_o == a_reg + b_reg) else $error("wrap add wrong");
    sub_wrap_a: assert property (s_take(WRAP_REG_SUBTRACT_OP) |=>
        narrow_acc_o == a_reg - b_reg) else $error("wrap subtract wrong");
    int_imm_add_op_wrap_a: assert property (s_take(INT_IMM_ADD_OP) |=>
        narrow_acc_o == a_reg + {{16{m_reg[15]}}, m_reg})
        else $error("immediate add wrong");
    lsr_imm_a: assert property (s_take(LOGIC_RIGHT_IMM_OP) |=>
        narrow_acc_o == a_reg >> m_reg[4:0]) else $error("right shift wrong");
    asr_reg_a: assert property (s_take(ARITH_RIGHT_REG_OP) |=>
        narrow_acc_o == 32'($signed(a_reg) >>> b_reg[4:0]))
        else $error("arithmetic shift wrong");
    clear_wide_a: assert property (s_take(WIDE_ACC_CLEAR_OP) ##0
        instr_i[24:0] == 25'h0000000 |=> wide_wr_o && wide_acc_o == 64'h0)
        else $error("wide clear wrong");
    refuse_op_a: assert property (instr_valid_i &&
        instr_i[31:25] > REG_MUL_ACCUMULATE_OP |=> unknown_op_o &&
        !narrow_wr_o && !wide_wr_o && $stable(wide_acc_o))
        else $error("unsupported op not refused");
    narrow_hold_a: assert property (!narrow_wr_o |-> $stable(narrow_acc_o))
        else $error("narrow acc moved without write");
    wide_hold_a: assert property ($changed(wide_acc_o) |-> wide_wr_o)
        else $error("wide acc moved without write");
endmodule : dmal_props

bind dmal_datapath dmal_props #(.NUM_GPR(NUM_GPR)) u_props (
    .clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .gpr_flat_i(gpr_flat_i), .flags_i(flags_i),
    .narrow_acc_o(narrow_acc_o), .wide_acc_o(wide_acc_o),
    .narrow_wr_o(narrow_wr_o), .wide_wr_o(wide_wr_o),
    .unknown_op_o(unknown_op_o));

// ### verif/dmal_regfile_model.sv
// Purpose: Register file and instruction encoder facing the datapath.
// Assumes: Loads are issued just after a rising clock edge.
// Notes:   Values stand until the next load, as real registers do.
`timescale 1ns/1ps
module dmal_regfile_model #(
    parameter int NUM_GPR = 16
) (
    output logic [NUM_GPR*32-1:0] gpr_flat_o,
    output logic [31:0]           flags_o
);
    // Registers start cleared so no operand is unknown.
    logic [31:0] regs_reg [NUM_GPR] = '{default: 32'h00000000};
    logic [31:0] flags_reg = 32'h00000000;  // Flags register contents.

    // Flatten with register 0 in the low bits, as the datapath expects.
    always_comb begin
        for (int i = 0; i < NUM_GPR; i++) gpr_flat_o[32*i +: 32] = regs_reg[i];
    end
    assign flags_o = flags_reg;

    // Non-blocking so a load at an edge never races the datapath.
    task automatic put(input int idx, input logic [31:0] v);
        regs_reg[idx] <= v;
    endtask : put
    task automatic put_flags(input logic [31:0] v);
        flags_reg <= v;
    endtask : put_flags

    // The reserved bit is always sent as zero.
    function automatic logic [31:0] word(input logic [6:0] op,
        input logic [4:0] s1, input logic [15:0] m);
        return {op, 1'b0, 3'h0, s1, m};
    endfunction : word
endmodule : dmal_regfile_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the math datapath.
// Assumes: One result a clock after each taken instruction.
// Notes:   Source fields use r5 and r9 unless a test says otherwise.
`timescale 1ns/1ps
module tb;
    import dmal_pkg::*;
    logic         clk_i = 1'b0;   // Core clock, 5 ns period.
    logic         reset_i;        // Asynchronous reset.
    logic         instr_valid_i;  // Instruction present.
    logic [31:0]  instr_i;        // Instruction word.
    logic [511:0] gpr_flat;       // Flattened general registers.
    logic [31:0]  flags;          // Flags register value.
    logic [31:0]  narrow_acc_o;   // Narrow accumulator.
    logic [63:0]  wide_acc_o;     // Wide accumulator.
    logic         narrow_wr_o;    // Narrow write pulse.
    logic         wide_wr_o;      // Wide write pulse.
    logic         unknown_op_o;   // Refusal pulse.
    int           n_errors = 0;   // Mismatches seen.
    int           checks_done = 0;  // Comparisons made.

    always #2.5 clk_i = ~clk_i;

    dmal_regfile_model rf (.gpr_flat_o(gpr_flat), .flags_o(flags));
    dmal_datapath dut (.clk_i(clk_i), .reset_i(reset_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .gpr_flat_i(gpr_flat), .flags_i(flags),
        .narrow_acc_o(narrow_acc_o), .wide_acc_o(wide_acc_o),
        .narrow_wr_o(narrow_wr_o), .wide_wr_o(wide_wr_o),
        .unknown_op_o(unknown_op_o));

    // ==================================================================
    // Reporting and comparisons.
    task automatic test_done;
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk32(input logic [31:0] g, x);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk32
    task automatic chk64(input logic [63:0] g, x);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk64
    task automatic chk1(input logic g, x);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR at %0t: flag %b want %b", $time, g, x);
        end
    endtask : chk1

    // ==================================================================
    // Bus cycles: one taken instruction, results sampled after it.
    task automatic go(input logic [31:0] w);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i       <= w;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask : go
    // Two-register operation with r5 first and r9 second.
    task automatic rr(input logic [6:0] op, input logic [31:0] a, b, x);
        rf.put(9, b);
        ri(op, a, 16'h0009, x);
        chk1(narrow_wr_o, 1'b1);
    endtask : rr
    // Register-and-immediate operation on r5.
    task automatic ri(input logic [6:0] op, input logic [31:0] a,
        input logic [15:0] m, input logic [31:0] x);
        rf.put(5, a);
        go(rf.word(op, 5'h05, m));
        chk32(narrow_acc_o, x);
    endtask : ri

    // ==================================================================
    // Scenarios.
    task automatic t_reg_ops;
        rr(WRAP_REG_ADD_OP, 32'hFFFFFFFF, 32'h00000002, 32'h00000001);
        rr(SAT_REG_ADD_OP, 32'h7FFFFFFF, 32'h00000001, MAX_POS_32);
        rr(SAT_REG_ADD_OP, 32'h80000000, 32'hFFFFFFFF, MAX_NEG_32);
        rr(WRAP_REG_SUBTRACT_OP, 32'h1, 32'h2, 32'hFFFFFFFF);
        rr(SAT_REG_SUBTRACT_OP, 32'h80000000, 32'h1, MAX_NEG_32);
        rr(SAT_REG_SUBTRACT_OP, 32'h7FFFFFFF, 32'hFFFFFFFF, MAX_POS_32);
        rr(LOGIC_LEFT_REG_OP, 32'h1, 32'h00000023, 32'h00000008);
        rr(SAT_LEFT_REG_OP, 32'h40000000, 32'h1, MAX_POS_32);
        rr(SAT_LEFT_REG_OP, 32'hA0000000, 32'h1, MAX_NEG_32);
        rr(SAT_LEFT_REG_OP, 32'hC0000000, 32'h1, 32'h80000000);
        rr(LOGIC_RIGHT_REG_OP, 32'h80000000, 32'h1F, 32'h00000001);
        rr(ARITH_RIGHT_REG_OP, 32'h80000000, 32'h4, 32'hF8000000);
        @(posedge clk_i);
        #1;
        chk1(narrow_wr_o, 1'b0);
    endtask : t_reg_ops
    task automatic t_imm_ops;
        ri(MAGNITUDE_OP, 32'hFFFFFFFB, 16'h0000, 32'h00000005);
        ri(MAGNITUDE_OP, MAX_NEG_32, 16'h0000, MAX_POS_32);
        ri(INT_IMM_ADD_OP, 32'h00000010, 16'hFFFF, 32'h0000000F);
        ri(INT_IMM_ADD_OP, 32'hFFFFFFFF, 16'h0001, 32'h00000000);
        ri(FRAC_IMM_SAT_ADD_OP, 32'h70000000, 16'h4000, MAX_POS_32);
        ri(FRAC_IMM_SAT_ADD_OP, 32'h90000000, 16'h8000, MAX_NEG_32);
        ri(LOGIC_LEFT_IMM_OP, 32'h00000003, 16'h0004, 32'h00000030);
        ri(SAT_LEFT_IMM_OP, 32'h00010000, 16'h0010, MAX_POS_32);
        ri(LOGIC_RIGHT_IMM_OP, 32'hF0000000, 16'h001C, 32'h0000000F);
        ri(ARITH_RIGHT_IMM_OP, 32'h80000000, 16'h001F, 32'hFFFFFFFF);
    endtask : t_imm_ops
    // Back to back: the second add reads the first one's result.
    task automatic t_select;
        @(posedge clk_i);
        rf.put(0, 32'h00000000);
        rf.put_flags(32'h12345678);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= rf.word(WRAP_REG_ADD_OP, SEL_FLAGS, 16'h0000);
        @(posedge clk_i);
        instr_i <= rf.word(WRAP_REG_ADD_OP, SEL_NARROW_ACC, 16'h0010);
        #1;
        chk32(narrow_acc_o, 32'h12345678);
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk32(narrow_acc_o, 32'h2468ACF0);
    endtask : t_select
    task automatic mac(input logic [31:0] a, b, input logic [63:0] x);
        rf.put(5, a);
        rf.put(9, b);
        go(rf.word(REG_MUL_ACCUMULATE_OP, 5'h05, 16'h0009));
        chk64(wide_acc_o, x);
    endtask : mac
    task automatic t_wide;
        go(rf.word(WIDE_ACC_CLEAR_OP, 5'h00, 16'h0000));
        chk64(wide_acc_o, WIDE_RESET);
        chk1(wide_wr_o, 1'b1);
        chk1(narrow_wr_o, 1'b0);
        mac(32'h40000000, 32'h40000000, 64'h2000000000000000);
        mac(32'h80000000, 32'h80000000, MAX_POS_64);
        mac(32'h80000000, 32'h7FFFFFFF, 64'h00000000FFFFFFFF);
        go(rf.word(WIDE_ACC_CLEAR_OP, 5'h00, 16'h0001));
        chk1(unknown_op_o, 1'b1);
        chk64(wide_acc_o, 64'h00000000FFFFFFFF);
        go(rf.word(7'h7F, 5'h05, 16'h0009));
        chk1(unknown_op_o, 1'b1);
        chk1(narrow_wr_o, 1'b0);
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        chk64(wide_acc_o, WIDE_RESET);
        mac(32'h40000000, 32'h40000000, 64'h2000000000000000);
        go(rf.word(WIDE_ACC_CLEAR_OP, 5'h00, 16'h0000));
        chk64(wide_acc_o, WIDE_RESET);
    endtask : t_wide

    // ==================================================================
    // Main sequence and hang guard.
    initial begin
        reset_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = 32'h00000000;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        chk32(narrow_acc_o, NARROW_RESET);
        chk1(unknown_op_o, 1'b0);
        t_reg_ops();
        t_imm_ops();
        t_select();
        t_wide();
        test_done();
    end
    // Bounded wait: running out counts as a mismatch.
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        test_done();
    end
endmodule : tb
